// >>> shared/cblm_pkg.sv
package cblm_pkg;
  // register byte offsets
  localparam logic [31:0] CBLM_OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] CBLM_OFF_STATUS = 32'h0000_0004;
  localparam logic [31:0] CBLM_OFF_CFG = 32'h0000_0008;
  // control fields and reset value
  localparam int CBLM_CTRL_EN_BIT = 0;
  localparam int CBLM_CTRL_REINIT_BIT = 1;
  localparam logic CBLM_CTRL_EN_RST = 1'h1;
  // status fields
  localparam int CBLM_ST_READY_BIT = 0;
  localparam int CBLM_ST_BUSY_BIT = 1;
  localparam int CBLM_ST_SLOT_LSB = 8;
  // configuration fields
  localparam int CBLM_CFG_BANKS_LSB = 0;
  localparam int CBLM_CFG_BYTES_LSB = 8;
  localparam int CBLM_CFG_COPIES_LSB = 16;
  localparam int CBLM_CFG_MEM_BIT = 24;
  localparam int CBLM_CFG_PUMP_BIT = 25;
  localparam int CBLM_CFG_DEPTH_BIT = 26;
  localparam int CBLM_CFG_INITR_BIT = 27;
  // read latency in component cycles
  localparam int CBLM_LAT_REG = 1;
  localparam int CBLM_LAT_MEM = 2;
  typedef enum logic [1:0] {
    CBLM_ST_INIT = 2'b01,
    CBLM_ST_RUN = 2'b10
  } cblm_state_type;
  function automatic int cblm_pow2_up(input int n);
    int p;
    p = 1;
    while (p < n) p = p * 2;
    return p;
  endfunction
endpackage

// >>> design/cblm_mem.sv
`timescale 1ns/1ns
// Operation
// - bank count is the power-of-two parameter
// - each bank is the requested bytes wide
// - select bits split memory into 2^n banks
// - without bank width, select bits start at zero
// - M read and N write dedicated ports
// - every port is read-only or write-only
// - single pump runs at the component rate
// - double pump serves two accesses per port
// - register mode keeps data in flip-flops
// - memory mode stores in addressed RAM array
// - unset options fall back to access-derived defaults; here each parameter has a fixed default value instead
// - reset reloads initial values by default
// - reset init uses an extra write port
// - power-up mode leaves contents across reset
// - depth merge stacks variables in address space
// - width merge places variables side by side
// - same label shares one memory, others separate
// - private copies rounded up to power of two
// - copies are the lesser of both limits
module cblm_mem import cblm_pkg::*; #(
  parameter int NUM_BANKS = 4,
  parameter int BANK_BYTES = 4,
  parameter int BANK_LSB = 0,
  parameter int NUM_RD = 1,
  parameter int NUM_WR = 1,
  parameter bit DOUBLE_PUMP = 1'b0,
  parameter bit IMPL_MEM = 1'b1,
  parameter bit MERGE_DEPTH = 1'b1,
  parameter bit INIT_ON_RESET = 1'b1,
  parameter int VAR_DEPTH = 16,
  parameter int MAX_CONC = 2,
  parameter int LOOP_MAX_CONC = 8,
  parameter logic [63:0] INIT_VALUE = 64'h0,
  localparam int NR = NUM_RD * (DOUBLE_PUMP ? 2 : 1),
  localparam int NW = NUM_WR * (DOUBLE_PUMP ? 2 : 1),
  localparam int WW = BANK_BYTES * 8,
  localparam int AW = $clog2(VAR_DEPTH),
  localparam int CP_REQ = cblm_pow2_up(MAX_CONC),
  localparam int COPIES = (CP_REQ < LOOP_MAX_CONC) ? CP_REQ : LOOP_MAX_CONC,
  localparam int SW = (COPIES > 1) ? $clog2(COPIES) : 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NR-1:0] i_rd_en,
  input wire logic [NR-1:0] i_rd_var,
  input wire logic [NR*AW-1:0] i_rd_addr,
  input wire logic [NR*SW-1:0] i_rd_slot,
  output logic [NR-1:0] o_rd_valid,
  output logic [NR*WW-1:0] o_rd_data,
  input wire logic [NW-1:0] i_wr_en,
  input wire logic [NW-1:0] i_wr_var,
  input wire logic [NW*AW-1:0] i_wr_addr,
  input wire logic [NW*SW-1:0] i_wr_slot,
  input wire logic [NW*WW-1:0] i_wr_data,
  input wire logic i_iter_start,
  input wire logic i_iter_done,
  input wire logic [SW-1:0] i_done_slot,
  output logic o_slot_grant,
  output logic o_slot_full,
  output logic [SW-1:0] o_slot_id,
  output logic o_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst || !i_ce);

  localparam int MD = MERGE_DEPTH ? 1 : 0;
  localparam int PAW = SW + MD + AW;
  localparam int BB = $clog2(NUM_BANKS);
  localparam int RW = PAW - BB;
  localparam int ROWS = 2 ** RW;
  localparam int HW = WW / 2;
  localparam logic [PAW-1:0] PA_LAST = {PAW{1'b1}};

  function automatic logic [PAW-1:0] pa_of(input logic [SW-1:0] slot,
                                           input logic vsel,
                                           input logic [AW-1:0] addr);
    logic [PAW-1:0] pa;
    pa = PAW'(addr);
    if (MERGE_DEPTH) begin
      pa = pa | (PAW'(vsel) << AW);
    end
    pa = pa | (PAW'(slot) << (AW + MD));
    return pa;
  endfunction

  function automatic logic [BB-1:0] bank_of(input logic [PAW-1:0] pa);
    return BB'(pa >> BANK_LSB);
  endfunction

  function automatic logic [RW-1:0] row_of(input logic [PAW-1:0] pa);
    logic [PAW-1:0] hi;
    logic [PAW-1:0] lo;
    hi = pa >> (BANK_LSB + BB);
    lo = pa & ((PAW'(1) << BANK_LSB) - PAW'(1));
    return RW'((hi << BANK_LSB) | lo);
  endfunction

  function automatic logic [WW-1:0] lane_mask(input logic vsel);
    logic [WW-1:0] m;
    m = {WW{1'b1}};
    if (!MERGE_DEPTH) begin
      m = vsel ? {{HW{1'b1}}, {HW{1'b0}}} : {{HW{1'b0}}, {HW{1'b1}}};
    end
    return m;
  endfunction

  // the array starts at the initial value, so power-up mode needs no init pass
  logic [WW-1:0] mem_ff [NUM_BANKS][ROWS] = '{default: '{default: WW'(INIT_VALUE)}};
  cblm_state_type state_ff;
  logic [PAW-1:0] init_cnt_ff;
  logic ctrl_en_ff;
  logic reinit_ff;
  logic [COPIES-1:0] busy_ff;
  logic ok;
  logic hit;
  logic [31:0] rd_word;

  // accesses are only taken while ready; the pipeline must wait on o_ready
  assign ok = o_ready;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff <= INIT_ON_RESET ? CBLM_ST_INIT : CBLM_ST_RUN;
      init_cnt_ff <= '0;
    end else if (i_ce) begin
      unique case (state_ff)
        CBLM_ST_INIT: begin
          init_cnt_ff <= init_cnt_ff + PAW'(1);
          if (init_cnt_ff == PA_LAST) begin
            state_ff <= CBLM_ST_RUN;
          end
        end
        CBLM_ST_RUN: begin
          if (reinit_ff) begin
            state_ff <= CBLM_ST_INIT;
            init_cnt_ff <= '0;
          end
        end
        default: begin
          state_ff <= CBLM_ST_INIT;
          init_cnt_ff <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ready <= 1'b0;
    end else if (i_ce) begin
      o_ready <= (state_ff == CBLM_ST_RUN) && !reinit_ff && ctrl_en_ff;
    end
  end

  // memory contents are never cleared by reset; the init pass rewrites them
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (state_ff == CBLM_ST_INIT) begin
        mem_ff[bank_of(init_cnt_ff)][row_of(init_cnt_ff)] <= WW'(INIT_VALUE);
      end else if (ok) begin
        for (int p = 0; p < NW; p++) begin
          logic [PAW-1:0] pa;
          logic [WW-1:0] m;
          pa = pa_of(i_wr_slot[p*SW +: SW], i_wr_var[p], i_wr_addr[p*AW +: AW]);
          m = lane_mask(i_wr_var[p]);
          if (i_wr_en[p]) begin
            // width-merged data is placed in its own lane of the word
            mem_ff[bank_of(pa)][row_of(pa)] <=
              (mem_ff[bank_of(pa)][row_of(pa)] & ~m) |
              ((MERGE_DEPTH || !i_wr_var[p]) ? i_wr_data[p*WW +: WW] & m :
               (i_wr_data[p*WW +: WW] << HW) & m);
          end
        end
      end
    end
  end

  // read ports are separate from write ports, so none serves both
  genvar gp;
  generate
    for (gp = 0; gp < NR; gp++) begin : g_rd
      logic [PAW-1:0] pa;
      assign pa = pa_of(i_rd_slot[gp*SW +: SW], i_rd_var[gp], i_rd_addr[gp*AW +: AW]);
      if (IMPL_MEM) begin : g_ram
        // address register then data register, as an embedded RAM block does
        logic [PAW-1:0] s1_pa_ff;
        logic s1_var_ff;
        logic s1_v_ff;
        always_ff @(posedge i_clk) begin
          if (i_srst) begin
            s1_v_ff <= 1'b0;
            s1_pa_ff <= '0;
            s1_var_ff <= 1'b0;
            o_rd_valid[gp] <= 1'b0;
            o_rd_data[gp*WW +: WW] <= '0;
          end else if (i_ce) begin
            s1_v_ff <= i_rd_en[gp] && ok;
            s1_pa_ff <= pa;
            s1_var_ff <= i_rd_var[gp];
            o_rd_valid[gp] <= s1_v_ff;
            o_rd_data[gp*WW +: WW] <= (!MERGE_DEPTH && s1_var_ff) ?
              (mem_ff[bank_of(s1_pa_ff)][row_of(s1_pa_ff)] >> HW) :
              (mem_ff[bank_of(s1_pa_ff)][row_of(s1_pa_ff)] & lane_mask(1'b0));
          end
        end
        a_rd_latency_mem: assert property (i_rd_en[gp] && ok |-> ##2 o_rd_valid[gp])
          else $error("memory read valid not two cycles after request");
        a_rd_refused_mem: assert property (i_rd_en[gp] && !ok |-> ##2 !o_rd_valid[gp])
          else $error("refused memory read was still answered");
      end else begin : g_reg
        always_ff @(posedge i_clk) begin
          if (i_srst) begin
            o_rd_valid[gp] <= 1'b0;
            o_rd_data[gp*WW +: WW] <= '0;
          end else if (i_ce) begin
            o_rd_valid[gp] <= i_rd_en[gp] && ok;
            o_rd_data[gp*WW +: WW] <= (!MERGE_DEPTH && i_rd_var[gp]) ?
              (mem_ff[bank_of(pa)][row_of(pa)] >> HW) :
              (mem_ff[bank_of(pa)][row_of(pa)] & lane_mask(1'b0));
          end
        end
        a_rd_latency_reg: assert property (i_rd_en[gp] && ok |=> o_rd_valid[gp])
          else $error("register read valid not one cycle after request");
        a_rd_refused_reg: assert property (i_rd_en[gp] && !ok |=> !o_rd_valid[gp])
          else $error("refused register read was still answered");
      end
    end
  endgenerate

  // iteration slots: lowest free copy is granted, released on done
  logic [COPIES-1:0] free_v;
  logic [SW-1:0] free_idx;
  logic any_free;
  always_comb begin
    free_v = ~busy_ff;
    if (i_iter_done) begin
      free_v[i_done_slot] = 1'b1;
    end
    free_idx = '0;
    any_free = 1'b0;
    for (int c = COPIES - 1; c >= 0; c--) begin
      if (free_v[c]) begin
        free_idx = SW'(c);
        any_free = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      busy_ff <= '0;
      o_slot_grant <= 1'b0;
      o_slot_full <= 1'b0;
      o_slot_id <= '0;
    end else if (i_ce) begin
      o_slot_grant <= i_iter_start && any_free;
      o_slot_full <= !any_free;
      if (i_iter_start && any_free) begin
        o_slot_id <= free_idx;
      end
      // a slot freed this cycle may be granted again at once
      busy_ff <= (busy_ff & ~(i_iter_done ? (COPIES'(1) << i_done_slot) : '0)) |
        ((i_iter_start && any_free) ? (COPIES'(1) << free_idx) : '0);
    end
  end

  // APB slave: answer one cycle into the access phase
  always_comb begin
    hit = (i_paddr == CBLM_OFF_CTRL) || (i_paddr == CBLM_OFF_STATUS) ||
      (i_paddr == CBLM_OFF_CFG);
    rd_word = '0;
    if (i_paddr == CBLM_OFF_CTRL) begin
      rd_word[CBLM_CTRL_EN_BIT] = ctrl_en_ff;
    end else if (i_paddr == CBLM_OFF_STATUS) begin
      rd_word[CBLM_ST_READY_BIT] = o_ready;
      rd_word[CBLM_ST_BUSY_BIT] = (state_ff == CBLM_ST_INIT);
      rd_word[CBLM_ST_SLOT_LSB +: 8] = 8'(busy_ff);
    end else if (i_paddr == CBLM_OFF_CFG) begin
      rd_word[CBLM_CFG_BANKS_LSB +: 8] = 8'(NUM_BANKS);
      rd_word[CBLM_CFG_BYTES_LSB +: 8] = 8'(BANK_BYTES);
      rd_word[CBLM_CFG_COPIES_LSB +: 8] = 8'(COPIES);
      rd_word[CBLM_CFG_MEM_BIT] = IMPL_MEM;
      rd_word[CBLM_CFG_PUMP_BIT] = DOUBLE_PUMP;
      rd_word[CBLM_CFG_DEPTH_BIT] = MERGE_DEPTH;
      rd_word[CBLM_CFG_INITR_BIT] = INIT_ON_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
      ctrl_en_ff <= CBLM_CTRL_EN_RST;
      reinit_ff <= 1'b0;
    end else if (i_ce) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      reinit_ff <= 1'b0;
      if (i_psel && i_penable && !o_pready) begin
        o_pready <= 1'b1;
        o_pslverr <= !hit;
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_word;
        if (i_pwrite && i_paddr == CBLM_OFF_CTRL) begin
          ctrl_en_ff <= i_pwdata[CBLM_CTRL_EN_BIT];
          reinit_ff <= i_pwdata[CBLM_CTRL_REINIT_BIT];
        end
      end
    end
  end

  sequence s_reinit_req;
    reinit_ff && state_ff == CBLM_ST_RUN;
  endsequence
  sequence s_init_entered;
    state_ff == CBLM_ST_INIT && init_cnt_ff == '0;
  endsequence
  sequence s_init_last;
    state_ff == CBLM_ST_INIT && init_cnt_ff == PA_LAST;
  endsequence

  a_apb_answer: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb access not answered in one cycle");
  a_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("apb ready stood longer than one cycle");
  a_pslverr_pair: assert property (o_pslverr |-> o_pready)
    else $error("slave error shown without ready");
  a_unmapped_err: assert property (i_psel && i_penable && !o_pready && !hit |=> o_pslverr)
    else $error("unmapped address gave no slave error");
  a_init_holdoff: assert property (state_ff == CBLM_ST_INIT |=> !o_ready)
    else $error("ready shown during init pass");
  a_ready_run: assert property (o_ready |-> state_ff == CBLM_ST_RUN)
    else $error("ready shown outside run state");
  a_init_step: assert property (state_ff == CBLM_ST_INIT && init_cnt_ff != PA_LAST |=>
      state_ff == CBLM_ST_INIT && init_cnt_ff == $past(init_cnt_ff) + PAW'(1))
    else $error("init pass skipped an entry");
  a_init_exit: assert property (s_init_last |=> state_ff == CBLM_ST_RUN)
    else $error("init pass did not end after last entry");
  a_init_restart: assert property (s_reinit_req |=> s_init_entered)
    else $error("reinit request did not restart init pass");
  a_init_full: assert property (state_ff == CBLM_ST_RUN && $past(state_ff) == CBLM_ST_INIT
      |-> $past(init_cnt_ff) == PA_LAST)
    else $error("init pass ended before last entry");
  a_reset_mode: assert property ($fell(i_srst) |->
      (state_ff == (INIT_ON_RESET ? CBLM_ST_INIT : CBLM_ST_RUN)))
    else $error("state after reset does not match init mode");
  a_slot_grant: assert property (o_slot_grant |->
      busy_ff[o_slot_id] && o_slot_id == $past(free_idx) &&
      $past(!busy_ff[free_idx] || i_iter_done && i_done_slot == free_idx))
    else $error("granted slot was already busy");
  a_slot_release: assert property (i_iter_done &&
      !(i_iter_start && any_free && free_idx == i_done_slot) |=> !busy_ff[$past(i_done_slot)])
    else $error("released slot still busy");
  a_copy_limit: assert property (i_iter_start && !any_free |=> !o_slot_grant && o_slot_full)
    else $error("slot granted beyond the copy count");
  // a low clock enable must freeze state, so this check keeps only the reset disable
  a_ce_freeze: assert property (disable iff (i_srst) !i_ce |=>
      $stable(busy_ff) && $stable(state_ff) && $stable(init_cnt_ff))
    else $error("state changed while clock enable was low");
endmodule // cblm_mem

// >>> testbench/cblm_pipe_model.sv
`timescale 1ns/1ns
// datapath side: one read port and one write port, each request held for one edge only
// slots name copies of loop-local data only; bank select is one field of the address
module cblm_pipe_model #(
  parameter int AW = 2,
  parameter int SW = 1,
  parameter int WW = 32
) (
  input wire logic i_clk,
  input wire logic i_rd_valid,
  input wire logic [WW-1:0] i_rd_data,
  output logic o_rd_en,
  output logic o_rd_var,
  output logic [AW-1:0] o_rd_addr,
  output logic [SW-1:0] o_rd_slot,
  output logic o_wr_en,
  output logic o_wr_var,
  output logic [AW-1:0] o_wr_addr,
  output logic [SW-1:0] o_wr_slot,
  output logic [WW-1:0] o_wr_data
);
  initial begin
    o_rd_en = 1'b0;
    o_rd_var = 1'b0;
    o_rd_addr = '0;
    o_rd_slot = '0;
    o_wr_en = 1'b0;
    o_wr_var = 1'b0;
    o_wr_addr = '0;
    o_wr_slot = '0;
    o_wr_data = '0;
  end

  // stale address and data are flipped after release so a leftover value never looks valid
  task automatic wr(input logic v, input logic [AW-1:0] a, input logic [SW-1:0] s,
                    input logic [WW-1:0] d);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_wr_var <= v;
    o_wr_addr <= a;
    o_wr_slot <= s;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_wr_addr <= ~a;
    o_wr_data <= ~d;
  endtask

  // n counts falling edges after the taking edge; 8 means no answer came
  task automatic rd(input logic v, input logic [AW-1:0] a, input logic [SW-1:0] s,
                    output logic [WW-1:0] d, output int n);
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_rd_var <= v;
    o_rd_addr <= a;
    o_rd_slot <= s;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_rd_addr <= ~a;
    n = 0;
    d = 'x;
    do begin
      @(negedge i_clk);
      n++;
    end while (i_rd_valid !== 1'b1 && n < 8);
    if (i_rd_valid === 1'b1) d = i_rd_data;
  endtask
endmodule // cblm_pipe_model

// >>> testbench/configurable_banked_local_memory_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module configurable_banked_local_memory_tb import cblm_pkg::*;;
  logic clk, srst, ce, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd_data, wr_data;
  logic rd_en, rd_var, rd_slot, rd_valid, wr_en, wr_var, wr_slot;
  logic [1:0] rd_addr, wr_addr;
  logic iter_start, iter_done, done_slot, slot_grant, slot_full, slot_id, ready;
  int mismatches = 0;
  int checks = 0;

  cblm_mem #(.VAR_DEPTH(4)) dut_u (.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rd_en(rd_en),
    .i_rd_var(rd_var), .i_rd_addr(rd_addr), .i_rd_slot(rd_slot), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_wr_en(wr_en), .i_wr_var(wr_var), .i_wr_addr(wr_addr),
    .i_wr_slot(wr_slot), .i_wr_data(wr_data), .i_iter_start(iter_start),
    .i_iter_done(iter_done), .i_done_slot(done_slot), .o_slot_grant(slot_grant),
    .o_slot_full(slot_full), .o_slot_id(slot_id), .o_ready(ready));
  cblm_pipe_model pp_u (.i_clk(clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_rd_en(rd_en), .o_rd_var(rd_var), .o_rd_addr(rd_addr), .o_rd_slot(rd_slot),
    .o_wr_en(wr_en), .o_wr_var(wr_var), .o_wr_addr(wr_addr), .o_wr_slot(wr_slot),
    .o_wr_data(wr_data));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results();
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // setup, then access until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    `CHK(ready, 1'b1)
  endtask

  task automatic iter(input logic st, input logic dn, input logic ds);
    @(posedge clk);
    iter_start <= st;
    iter_done <= dn;
    done_slot <= ds;
    @(posedge clk);
    iter_start <= 1'b0;
    iter_done <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_regs();
    logic [31:0] d, e;
    logic err;
    e = (32'h4 << CBLM_CFG_BANKS_LSB) | (32'h4 << CBLM_CFG_BYTES_LSB);
    e = e | (32'h2 << CBLM_CFG_COPIES_LSB) | (32'h1 << CBLM_CFG_MEM_BIT);
    e = e | (32'h1 << CBLM_CFG_DEPTH_BIT) | (32'h1 << CBLM_CFG_INITR_BIT);
    apb(1'b0, CBLM_OFF_CFG, 32'h0, d, err);
    `CHK(d, e)
    apb(1'b0, CBLM_OFF_CTRL, 32'h0, d, err);
    `CHK(d, 32'h0000_0001)
    apb(1'b0, CBLM_OFF_STATUS, 32'h0, d, err);
    `CHK(d[CBLM_ST_READY_BIT], 1'b1)
    apb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, d, err);
    `CHK(err, 1'b1)
    apb(1'b0, 32'h0000_0010, 32'h0, d, err);
    `CHK({err, d}, {1'b1, 32'h0})
  endtask

  // four cells share address 1: two variables times two private copies
  task automatic t_mem();
    logic [31:0] d;
    int n;
    for (int k = 0; k < 4; k++) pp_u.wr(k[0], 2'h1, k[1], 32'h5A00_0010 + k);
    for (int k = 0; k < 4; k++) begin
      pp_u.rd(k[0], 2'h1, k[1], d, n);
      `CHK(d, 32'h5A00_0010 + k)
      `CHK(n, CBLM_LAT_MEM)
    end
  endtask

  task automatic t_slots();
    for (int k = 0; k < 2; k++) begin
      iter(1'b1, 1'b0, 1'b0);
      `CHK({slot_grant, slot_id}, {1'b1, k[0]})
    end
    iter(1'b1, 1'b0, 1'b0);
    `CHK({slot_grant, slot_full}, 2'b01)
    iter(1'b0, 1'b1, 1'b0);
    iter(1'b1, 1'b0, 1'b0);
    `CHK({slot_grant, slot_id}, 2'b10)
  endtask

  // both slots busy: a release while the clock enable is low must be lost
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    iter(1'b0, 1'b1, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    iter(1'b1, 1'b0, 1'b0);
    `CHK({slot_grant, slot_full}, 2'b01)
  endtask

  // restart the init pass: accesses refused, then contents back to the initial value
  task automatic t_reinit();
    logic [31:0] d;
    logic err;
    int n;
    apb(1'b1, CBLM_OFF_CTRL, 32'h0000_0003, d, err);
    @(negedge clk);
    `CHK(ready, 1'b0)
    pp_u.rd(1'b0, 2'h1, 1'b0, d, n);
    `CHK(n, 8)
    wait_ready(40);
    pp_u.rd(1'b0, 2'h1, 1'b1, d, n);
    `CHK(d, 32'h0)
    apb(1'b0, CBLM_OFF_CTRL, 32'h0, d, err);
    `CHK(d, 32'h0000_0001)
  endtask

  initial begin
    #300000;
    mismatches++;
    results();
  end

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    iter_start = 1'b0;
    iter_done = 1'b0;
    done_slot = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    wait_ready(40);
    t_regs();
    t_mem();
    t_slots();
    t_freeze();
    t_reinit();
    results();
  end
endmodule // configurable_banked_local_memory_tb
